/* pkg/bbi2c_regs.svh */
// register map, field positions, reset values and timing counts of the i2c master
`ifndef BBI2C_REGS_SVH
`define BBI2C_REGS_SVH

`define BBI2C_SETUP_ADDR   32'h00103400
`define BBI2C_WIN_ADDR     32'h00103404
`define BBI2C_STAT_ADDR    32'h00103408
`define BBI2C_CTRL_ADDR    32'h0010340c

`define BBI2C_CTRL_RST     32'h00000000
`define BBI2C_CTRL_EN      0
`define BBI2C_CTRL_SCL_PULL 6
`define BBI2C_CTRL_SDA_PULL 7
`define BBI2C_CTRL_OVR     10
`define BBI2C_CTRL_CLR_LO  22
`define BBI2C_CTRL_IEN_LO  28

`define BBI2C_SETUP_ADDR_LO 25
`define BBI2C_SETUP_DIR    24
`define BBI2C_SETUP_CNT_LO 8

`define BBI2C_STAT_FLG_LO  28
`define BBI2C_STAT_RBC_LO  8
`define BBI2C_STAT_STATE_LO 4
`define BBI2C_STAT_DIR     3
`define BBI2C_STAT_SDA     1
`define BBI2C_STAT_SCL     0

`define BBI2C_FLG_DONE     3
`define BBI2C_FLG_SVC      2
`define BBI2C_FLG_ANAK     1
`define BBI2C_FLG_DNAK     0

`define BBI2C_CODE_IDLE    3'h0
`define BBI2C_CODE_START   3'h1
`define BBI2C_CODE_TX      3'h2
`define BBI2C_CODE_RX      3'h3
`define BBI2C_CODE_STOP    3'h4
`define BBI2C_CODE_WAIT    3'h5

`define BBI2C_DIV_STD_0    10'h3f0
`define BBI2C_DIV_STD_1    10'h2f0
`define BBI2C_DIV_STD_2    10'h200
`define BBI2C_DIV_STD_3    10'h150
`define BBI2C_DIV_FAST_0   10'h100
`define BBI2C_DIV_FAST_1   10'h0c0
`define BBI2C_DIV_FAST_2   10'h080
`define BBI2C_DIV_FAST_3   10'h060
`define BBI2C_CHUNK_MAX    3'h4

`endif

/* pkg/bbi2c_pkg.sv */
// types shared by the i2c master modules
package bbi2c_pkg;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_START = 5'b00010,
		ST_BYTE  = 5'b00100,
		ST_WAIT  = 5'b01000,
		ST_STOP  = 5'b10000
	} bbi2c_state_t;
endpackage

/* rtl/bbi2c_clkdiv.sv */
// boot-fixed serial clock divider producing quarter-bit ticks
`include "bbi2c_regs.svh"
module bbi2c_clkdiv (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       clk_en,
	// boot straps
	input  wire logic [1:0] boot_clk_sel,
	input  wire logic       boot_fast,
	// engine
	input  wire logic       run,
	input  wire logic       hold,
	output logic            tick
);
	import bbi2c_pkg::*;

	logic       captured_ff;
	logic       nxt_captured;
	logic [7:0] quarter_ff;
	logic [7:0] nxt_quarter;
	logic [7:0] cnt_ff;
	logic [7:0] nxt_cnt;
	logic       tick_ff;
	logic       nxt_tick;
	logic [9:0] div_sel;

	function automatic logic [9:0] divider(input logic [1:0] sel, input logic fast);
		logic [9:0] d;
		d = `BBI2C_DIV_STD_0;
		case ({fast, sel})
			3'h0: d = `BBI2C_DIV_STD_0;
			3'h1: d = `BBI2C_DIV_STD_1;
			3'h2: d = `BBI2C_DIV_STD_2;
			3'h3: d = `BBI2C_DIV_STD_3;
			3'h4: d = `BBI2C_DIV_FAST_0;
			3'h5: d = `BBI2C_DIV_FAST_1;
			3'h6: d = `BBI2C_DIV_FAST_2;
			default: d = `BBI2C_DIV_FAST_3;
		endcase
		return d;
	endfunction

	always_comb begin
		div_sel      = divider(boot_clk_sel, boot_fast);
		// straps caught once after release, never again
		nxt_captured = 1'b1;
		nxt_quarter  = captured_ff ? quarter_ff : div_sel[9:2];
		nxt_tick     = 1'b0;
		nxt_cnt      = cnt_ff;
		if (!run) begin
			nxt_cnt = 8'h00;
		end else if (hold) begin
			nxt_cnt = cnt_ff;
		end else if (cnt_ff >= 8'(quarter_ff - 8'h01)) begin
			nxt_cnt  = 8'h00;
			nxt_tick = 1'b1;
		end else begin
			nxt_cnt = 8'(cnt_ff + 8'h01);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			captured_ff <= 1'b0;
			quarter_ff  <= 8'h00;
			cnt_ff      <= 8'h00;
			tick_ff     <= 1'b0;
		end else if (clk_en) begin
			captured_ff <= nxt_captured;
			quarter_ff  <= nxt_quarter;
			cnt_ff      <= nxt_cnt;
			tick_ff     <= nxt_tick;
		end
	end

	assign tick = tick_ff;
endmodule

/* rtl/bbi2c_pins.sv */
// open-drain pin selection between override bits and engine, line status
`include "bbi2c_regs.svh"
module bbi2c_pins (
	// clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic clk_en,
	// drive requests
	input  wire logic override,
	input  wire logic sw_sda_pull,
	input  wire logic sw_scl_pull,
	input  wire logic hw_sda_pull,
	input  wire logic hw_scl_pull,
	// pins
	input  wire logic sda_i,
	output logic      sda_o,
	output logic      sda_oe,
	input  wire logic scl_i,
	output logic      scl_o,
	output logic      scl_oe,
	// line status
	output logic      sda_low,
	output logic      scl_low
);
	import bbi2c_pkg::*;

	logic sda_oe_ff;
	logic scl_oe_ff;
	logic sda_low_ff;
	logic scl_low_ff;
	logic nxt_sda_oe;
	logic nxt_scl_oe;
	logic nxt_sda_low;
	logic nxt_scl_low;
	logic drive_lvl_ff;

	always_comb begin
		// engine is cut off entirely while override is on
		nxt_sda_oe  = override ? sw_sda_pull : hw_sda_pull;
		nxt_scl_oe  = override ? sw_scl_pull : hw_scl_pull;
		// reads the wire, so external pull-downs show as well
		nxt_sda_low = ~sda_i;
		nxt_scl_low = ~scl_i;
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			sda_oe_ff    <= 1'b0;
			scl_oe_ff    <= 1'b0;
			sda_low_ff   <= 1'b0;
			scl_low_ff   <= 1'b0;
			drive_lvl_ff <= 1'b0;
		end else if (clk_en) begin
			sda_oe_ff    <= nxt_sda_oe;
			scl_oe_ff    <= nxt_scl_oe;
			sda_low_ff   <= nxt_sda_low;
			scl_low_ff   <= nxt_scl_low;
			drive_lvl_ff <= 1'b0;
		end
	end

	// open drain: level is always low, only the enable moves
	assign sda_o   = drive_lvl_ff;
	assign scl_o   = drive_lvl_ff;
	assign sda_oe  = sda_oe_ff;
	assign scl_oe  = scl_oe_ff;
	assign sda_low = sda_low_ff;
	assign scl_low = scl_low_ff;
endmodule

/* rtl/bbi2c_top.sv */
// i2c master with register window engine and pin override mode
`include "bbi2c_regs.svh"
module bbi2c_top (
	// clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic        clk_en,
	// boot straps
	input  wire logic [1:0]  boot_clk_sel,
	input  wire logic        boot_fast,
	// register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	// serial pins
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	// event request
	output logic             irq_req
);
	import bbi2c_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// control group
	logic [3:0]   ien_ff, nxt_ien;
	logic         ovr_ff, nxt_ovr;
	logic         sda_sw_ff, nxt_sda_sw;
	logic         scl_sw_ff, nxt_scl_sw;
	logic         en_ff, nxt_en;
	logic [31:0]  rdata_ff, nxt_rdata;
	logic         irq_ff, nxt_irq;
	// engine group
	bbi2c_state_t state_ff, nxt_state;
	logic [1:0]   phase_ff, nxt_phase;
	logic [3:0]   bit_ff, nxt_bit;
	logic [7:0]   shift_ff, nxt_shift;
	logic         is_addr_ff, nxt_is_addr;
	logic [2:0]   chunk_ff, nxt_chunk;
	logic [1:0]   idx_ff, nxt_idx;
	logic         sda_pull_ff, nxt_sda_pull;
	logic         scl_pull_ff, nxt_scl_pull;
	logic         nak_ff, nxt_nak;
	logic         ack_ok_ff, nxt_ack_ok;
	logic [6:0]   addr_ff, nxt_addr;
	logic         dir_ff, nxt_dir;
	logic [7:0]   cnt_ff, nxt_cnt;
	logic [7:0]   rbc_ff, nxt_rbc;
	logic [31:0]  window_ff, nxt_window;
	logic [3:0]   flags_ff, nxt_flags;
	// glue
	logic         wr_ctrl, wr_setup, wr_win, rd_win;
	logic [3:0]   clr, set;
	logic         tick, run, hold, tx, active;
	logic         sda_low, scl_low;
	logic [7:0]   rbc_dec;
	logic [2:0]   state_code;

	function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
		return a == r;
	endfunction

	function automatic logic [2:0] chunk_of(input logic [7:0] n);
		return (n >= 8'h04) ? `BBI2C_CHUNK_MAX : n[2:0];
	endfunction

	function automatic logic [7:0] byte_get(input logic [31:0] w, input logic [1:0] i);
		logic [7:0] b;
		b = w[31:24];
		case (i)
			2'h0: b = w[31:24];
			2'h1: b = w[23:16];
			2'h2: b = w[15:8];
			default: b = w[7:0];
		endcase
		return b;
	endfunction

	function automatic logic [31:0] byte_put(input logic [31:0] w, input logic [1:0] i,
			input logic [7:0] b);
		logic [31:0] r;
		r = w;
		case (i)
			2'h0: r[31:24] = b;
			2'h1: r[23:16] = b;
			2'h2: r[15:8] = b;
			default: r[7:0] = b;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus decode
	always_comb begin
		wr_ctrl  = reg_wr & hit(reg_addr, `BBI2C_CTRL_ADDR);
		wr_setup = reg_wr & hit(reg_addr, `BBI2C_SETUP_ADDR);
		wr_win   = reg_wr & hit(reg_addr, `BBI2C_WIN_ADDR);
		rd_win   = reg_rd & hit(reg_addr, `BBI2C_WIN_ADDR);
		clr      = wr_ctrl ? reg_wdata[`BBI2C_CTRL_CLR_LO +: 4] : 4'h0;
		active   = en_ff & ~ovr_ff;
		tx       = is_addr_ff | ~dir_ff;
		run      = (state_ff != ST_IDLE) && (state_ff != ST_WAIT);
		hold     = run & ~scl_pull_ff & scl_low;
		rbc_dec  = 8'(rbc_ff - 8'h01);
	end

	always_comb begin
		case (state_ff)
			ST_IDLE:  state_code = `BBI2C_CODE_IDLE;
			ST_START: state_code = `BBI2C_CODE_START;
			ST_BYTE:  state_code = tx ? `BBI2C_CODE_TX : `BBI2C_CODE_RX;
			ST_WAIT:  state_code = `BBI2C_CODE_WAIT;
			ST_STOP:  state_code = nak_ff ? `BBI2C_CODE_IDLE : `BBI2C_CODE_STOP;
			default:  state_code = `BBI2C_CODE_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// control registers and read mux
	always_comb begin
		nxt_ien    = ien_ff;
		nxt_ovr    = ovr_ff;
		nxt_sda_sw = sda_sw_ff;
		nxt_scl_sw = scl_sw_ff;
		nxt_en     = en_ff;
		if (wr_ctrl) begin
			nxt_ien    = reg_wdata[`BBI2C_CTRL_IEN_LO +: 4];
			nxt_ovr    = reg_wdata[`BBI2C_CTRL_OVR];
			nxt_sda_sw = reg_wdata[`BBI2C_CTRL_SDA_PULL];
			nxt_scl_sw = reg_wdata[`BBI2C_CTRL_SCL_PULL];
			nxt_en     = reg_wdata[`BBI2C_CTRL_EN];
		end
		nxt_rdata = rdata_ff;
		if (reg_rd) begin
			nxt_rdata = 32'h00000000;
			if (hit(reg_addr, `BBI2C_CTRL_ADDR)) begin
				nxt_rdata[`BBI2C_CTRL_IEN_LO +: 4] = ien_ff;
				nxt_rdata[`BBI2C_CTRL_OVR]         = ovr_ff;
				nxt_rdata[`BBI2C_CTRL_SDA_PULL]    = sda_sw_ff;
				nxt_rdata[`BBI2C_CTRL_SCL_PULL]    = scl_sw_ff;
				nxt_rdata[`BBI2C_CTRL_EN]          = en_ff;
			end else if (hit(reg_addr, `BBI2C_SETUP_ADDR)) begin
				nxt_rdata[`BBI2C_SETUP_ADDR_LO +: 7] = addr_ff;
				nxt_rdata[`BBI2C_SETUP_DIR]          = dir_ff;
				nxt_rdata[`BBI2C_SETUP_CNT_LO +: 8]  = cnt_ff;
			end else if (hit(reg_addr, `BBI2C_WIN_ADDR)) begin
				nxt_rdata = window_ff;
			end else if (hit(reg_addr, `BBI2C_STAT_ADDR)) begin
				nxt_rdata[`BBI2C_STAT_FLG_LO +: 4]   = flags_ff;
				nxt_rdata[`BBI2C_STAT_RBC_LO +: 8]   = rbc_ff;
				nxt_rdata[`BBI2C_STAT_STATE_LO +: 3] = state_code;
				nxt_rdata[`BBI2C_STAT_DIR]           = dir_ff;
				nxt_rdata[`BBI2C_STAT_SDA]           = sda_low;
				nxt_rdata[`BBI2C_STAT_SCL]           = scl_low;
			end
		end
		nxt_irq = |(flags_ff & ien_ff);
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ien_ff    <= 4'(`BBI2C_CTRL_RST >> `BBI2C_CTRL_IEN_LO);
			ovr_ff    <= 1'(`BBI2C_CTRL_RST >> `BBI2C_CTRL_OVR);
			sda_sw_ff <= 1'(`BBI2C_CTRL_RST >> `BBI2C_CTRL_SDA_PULL);
			scl_sw_ff <= 1'(`BBI2C_CTRL_RST >> `BBI2C_CTRL_SCL_PULL);
			en_ff     <= 1'(`BBI2C_CTRL_RST >> `BBI2C_CTRL_EN);
			rdata_ff  <= 32'h00000000;
			irq_ff    <= 1'b0;
		end else if (clk_en) begin
			ien_ff    <= nxt_ien;
			ovr_ff    <= nxt_ovr;
			sda_sw_ff <= nxt_sda_sw;
			scl_sw_ff <= nxt_scl_sw;
			en_ff     <= nxt_en;
			rdata_ff  <= nxt_rdata;
			irq_ff    <= nxt_irq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// serial engine, master only, four ticks per bit
	always_comb begin
		nxt_state    = state_ff;
		nxt_phase    = phase_ff;
		nxt_bit      = bit_ff;
		nxt_shift    = shift_ff;
		nxt_is_addr  = is_addr_ff;
		nxt_chunk    = chunk_ff;
		nxt_idx      = idx_ff;
		nxt_sda_pull = sda_pull_ff;
		nxt_scl_pull = scl_pull_ff;
		nxt_nak      = nak_ff;
		nxt_ack_ok   = ack_ok_ff;
		nxt_addr     = addr_ff;
		nxt_dir      = dir_ff;
		nxt_cnt      = cnt_ff;
		nxt_rbc      = rbc_ff;
		nxt_window   = window_ff;
		set          = 4'h0;
		case (state_ff)
			ST_IDLE: begin
				nxt_sda_pull = 1'b0;
				nxt_scl_pull = 1'b0;
				nxt_phase    = 2'h0;
				if (active && wr_setup) begin
					nxt_addr  = reg_wdata[`BBI2C_SETUP_ADDR_LO +: 7];
					nxt_dir   = reg_wdata[`BBI2C_SETUP_DIR];
					nxt_cnt   = reg_wdata[`BBI2C_SETUP_CNT_LO +: 8];
					nxt_rbc   = reg_wdata[`BBI2C_SETUP_CNT_LO +: 8];
					nxt_chunk = chunk_of(reg_wdata[`BBI2C_SETUP_CNT_LO +: 8]);
					nxt_idx   = 2'h0;
					if (reg_wdata[`BBI2C_SETUP_DIR] &&
							reg_wdata[`BBI2C_SETUP_CNT_LO +: 8] != 8'h00) begin
						nxt_window = 32'h00000000;
						nxt_state  = ST_START;
					end
				end else if (active && wr_win && !dir_ff && rbc_ff != 8'h00) begin
					nxt_window = reg_wdata;
					nxt_chunk  = chunk_of(rbc_ff);
					nxt_idx    = 2'h0;
					nxt_state  = ST_START;
				end
			end
			ST_START: if (tick) begin
				nxt_phase = 2'(phase_ff + 2'h1);
				case (phase_ff)
					2'h1: nxt_sda_pull = 1'b1;
					2'h2: nxt_scl_pull = 1'b1;
					2'h3: begin
						nxt_state    = ST_BYTE;
						nxt_is_addr  = 1'b1;
						nxt_bit      = 4'h0;
						nxt_shift    = {addr_ff, dir_ff};
						nxt_sda_pull = ~addr_ff[6];
					end
					default: ;
				endcase
			end
			ST_BYTE: if (tick) begin
				nxt_phase = 2'(phase_ff + 2'h1);
				case (phase_ff)
					2'h0: nxt_scl_pull = 1'b0;
					2'h1: begin
						if (bit_ff == 4'h8) begin
							nxt_ack_ok = sda_low;
						end else if (!tx) begin
							nxt_shift = {shift_ff[6:0], ~sda_low};
						end
					end
					2'h2: nxt_scl_pull = 1'b1;
					default: begin
						if (bit_ff != 4'h8) begin
							nxt_bit = 4'(bit_ff + 4'h1);
							if (bit_ff == 4'h7) begin
								// ack slot: transmitter lets go, receiver pulls except on the last byte
								nxt_sda_pull = tx ? 1'b0 : (rbc_ff != 8'h01);
							end else begin
								nxt_sda_pull = tx ? ~shift_ff[6 - bit_ff[2:0]] : 1'b0;
							end
						end else if (tx && !ack_ok_ff) begin
							// refused byte ends the transfer here
							set[`BBI2C_FLG_ANAK] = is_addr_ff;
							set[`BBI2C_FLG_DNAK] = ~is_addr_ff;
							nxt_nak      = 1'b1;
							nxt_sda_pull = 1'b1;
							nxt_state    = ST_STOP;
						end else if (is_addr_ff) begin
							nxt_is_addr  = 1'b0;
							nxt_bit      = 4'h0;
							nxt_shift    = byte_get(window_ff, idx_ff);
							nxt_sda_pull = dir_ff ? 1'b0 : ~nxt_shift[7];
						end else begin
							nxt_rbc   = rbc_dec;
							nxt_chunk = 3'(chunk_ff - 3'h1);
							nxt_idx   = 2'(idx_ff + 2'h1);
							nxt_bit   = 4'h0;
							if (dir_ff) begin
								nxt_window = byte_put(window_ff, idx_ff, shift_ff);
							end
							if (rbc_dec == 8'h00) begin
								set[`BBI2C_FLG_DONE] = 1'b1;
								nxt_sda_pull = 1'b1;
								nxt_state    = ST_STOP;
							end else if (chunk_ff == 3'h1) begin
								// clock held low while software services the window
								set[`BBI2C_FLG_SVC] = 1'b1;
								nxt_sda_pull = 1'b0;
								nxt_state    = ST_WAIT;
							end else begin
								nxt_shift    = byte_get(window_ff, 2'(idx_ff + 2'h1));
								nxt_sda_pull = dir_ff ? 1'b0 : ~nxt_shift[7];
							end
						end
					end
				endcase
			end
			ST_WAIT: begin
				nxt_phase = 2'h0;
				if (!dir_ff && wr_win) begin
					nxt_window   = reg_wdata;
					nxt_chunk    = chunk_of(rbc_ff);
					nxt_idx      = 2'h0;
					nxt_shift    = reg_wdata[31:24];
					nxt_sda_pull = ~reg_wdata[31];
					nxt_state    = ST_BYTE;
				end else if (dir_ff && rd_win) begin
					// old contents latched into the read data on this same edge
					nxt_window = 32'h00000000;
					nxt_chunk  = chunk_of(rbc_ff);
					nxt_idx    = 2'h0;
					nxt_state  = ST_BYTE;
				end
			end
			ST_STOP: if (tick) begin
				nxt_phase = 2'(phase_ff + 2'h1);
				case (phase_ff)
					2'h0: nxt_scl_pull = 1'b0;
					2'h1: nxt_sda_pull = 1'b0;
					2'h3: begin
						nxt_nak   = 1'b0;
						nxt_state = ST_IDLE;
					end
					default: ;
				endcase
			end
			default: nxt_state = ST_IDLE;
		endcase
		// set beats clear in the same cycle
		nxt_flags = (flags_ff & ~clr) | set;
		if (!active) begin
			// disable or override abandons the byte in flight
			nxt_state    = ST_IDLE;
			nxt_phase    = 2'h0;
			nxt_sda_pull = 1'b0;
			nxt_scl_pull = 1'b0;
			nxt_nak      = 1'b0;
		end
		if (!en_ff) begin
			nxt_flags  = 4'h0;
			nxt_rbc    = 8'h00;
			nxt_window = 32'h00000000;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_ff    <= ST_IDLE;
			phase_ff    <= 2'h0;
			bit_ff      <= 4'h0;
			shift_ff    <= 8'h00;
			is_addr_ff  <= 1'b0;
			chunk_ff    <= 3'h0;
			idx_ff      <= 2'h0;
			sda_pull_ff <= 1'b0;
			scl_pull_ff <= 1'b0;
			nak_ff      <= 1'b0;
			ack_ok_ff   <= 1'b0;
			addr_ff     <= 7'h00;
			dir_ff      <= 1'b0;
			cnt_ff      <= 8'h00;
			rbc_ff      <= 8'h00;
			window_ff   <= 32'h00000000;
			flags_ff    <= 4'h0;
		end else if (clk_en) begin
			state_ff    <= nxt_state;
			phase_ff    <= nxt_phase;
			bit_ff      <= nxt_bit;
			shift_ff    <= nxt_shift;
			is_addr_ff  <= nxt_is_addr;
			chunk_ff    <= nxt_chunk;
			idx_ff      <= nxt_idx;
			sda_pull_ff <= nxt_sda_pull;
			scl_pull_ff <= nxt_scl_pull;
			nak_ff      <= nxt_nak;
			ack_ok_ff   <= nxt_ack_ok;
			addr_ff     <= nxt_addr;
			dir_ff      <= nxt_dir;
			cnt_ff      <= nxt_cnt;
			rbc_ff      <= nxt_rbc;
			window_ff   <= nxt_window;
			flags_ff    <= nxt_flags;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// submodules
	bbi2c_clkdiv u_clkdiv (
		.clk_sys      (clk_sys),
		.rst          (rst),
		.clk_en       (clk_en),
		.boot_clk_sel (boot_clk_sel),
		.boot_fast    (boot_fast),
		.run          (run),
		.hold         (hold),
		.tick         (tick)
	);

	bbi2c_pins u_pins (
		.clk_sys     (clk_sys),
		.rst         (rst),
		.clk_en      (clk_en),
		.override    (ovr_ff),
		.sw_sda_pull (sda_sw_ff),
		.sw_scl_pull (scl_sw_ff),
		.hw_sda_pull (sda_pull_ff),
		.hw_scl_pull (scl_pull_ff),
		.sda_i       (sda_i),
		.sda_o       (sda_o),
		.sda_oe      (sda_oe),
		.scl_i       (scl_i),
		.scl_o       (scl_o),
		.scl_oe      (scl_oe),
		.sda_low     (sda_low),
		.scl_low     (scl_low)
	);

	assign reg_rdata = rdata_ff;
	assign irq_req   = irq_ff;
endmodule

/* verif/bbi2c_top_sva.sv */
// concurrent checks on the i2c master top ports
`include "bbi2c_regs.svh"
module bbi2c_top_sva (
	// clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// register port
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	// pins and event
	input wire logic        sda_i,
	input wire logic        sda_oe,
	input wire logic        scl_i,
	input wire logic        scl_oe,
	input wire logic        irq_req
);
	logic       ovr_ff, sda_ff, scl_ff;
	logic [3:0] ien_ff;
	logic       wr_ctl;
	assign wr_ctl = reg_wr && reg_addr == `BBI2C_CTRL_ADDR;
	// shadow of the control bits, taken on the same edge as the design
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			{ovr_ff, sda_ff, scl_ff, ien_ff} <= 7'h00;
		end else if (wr_ctl) begin
			{ovr_ff, sda_ff, scl_ff, ien_ff} <= {reg_wdata[10], reg_wdata[7:6], reg_wdata[31:28]};
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	sequence hw_start;
		!ovr_ff && !scl_oe && $rose(sda_oe);
	endsequence
	sequence hw_stop;
		!ovr_ff && !scl_oe && $fell(sda_oe);
	endsequence
	a_start_then_clock: assert property (hw_start |-> ##[1:40] scl_oe)
		else $error("clock not pulled after start");
	a_stop_frees_bus: assert property (hw_stop |=> (!sda_oe && !scl_oe) [*8])
		else $error("bus not free after stop");
	a_stretch_honour: assert property (!ovr_ff && $rose(scl_i) |-> !scl_oe [*8])
		else $error("clock high phase cut short");
	a_override_data: assert property (ovr_ff && $past(ovr_ff, 2) && sda_ff == $past(sda_ff)
		&& sda_ff == $past(sda_ff, 2) |-> sda_oe == sda_ff)
		else $error("data pin not following override bit");
	a_override_clock: assert property (ovr_ff && $past(ovr_ff, 2) && scl_ff == $past(scl_ff)
		&& scl_ff == $past(scl_ff, 2) |-> scl_oe == scl_ff)
		else $error("clock pin not following override bit");
	a_ctrl_readback: assert property (reg_rd && reg_addr == `BBI2C_CTRL_ADDR |=>
		reg_rdata[25:22] == 4'h0 && reg_rdata[10] == $past(ovr_ff)
		&& reg_rdata[31:28] == $past(ien_ff))
		else $error("control readback wrong");
	a_irq_masked: assert property (ien_ff == 4'h0 && $past(ien_ff) == 4'h0 |-> !irq_req)
		else $error("event request while all sources masked");
	a_disable_abort: assert property (wr_ctl && !reg_wdata[0] && !reg_wdata[10] |->
		##3 !(irq_req || sda_oe || scl_oe))
		else $error("disable did not reset interface");
	a_line_status: assert property (reg_rd && reg_addr == `BBI2C_STAT_ADDR
		&& $stable({sda_i, scl_i}) && {sda_i, scl_i} == $past({sda_i, scl_i}, 2) |=>
		reg_rdata[1:0] == ~$past({sda_i, scl_i}))
		else $error("line status bits wrong");
endmodule
bind bbi2c_top bbi2c_top_sva u_sva (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.sda_i(sda_i), .sda_oe(sda_oe), .scl_i(scl_i), .scl_oe(scl_oe), .irq_req(irq_req));

/* verif/bbi2c_slave_model.sv */
// behavioural i2c slave: acks, records written bytes, returns rd_byte on every read
module bbi2c_slave_model (
	// wires
	input wire logic       scl,
	input wire logic       sda,
	output logic           sda_pull,
	output logic           scl_pull,
	// bench control and observation
	input wire logic       nak,
	input wire logic       stretch,
	input wire logic [7:0] rd_byte,
	output logic     [7:0] got,
	output logic           got_tgl
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] b;
	task automatic rx();
		for (int i = 0; i < 8; i++) begin
			@(posedge scl);
			b = {b[6:0], sda};
		end
		got = b;
		got_tgl = ~got_tgl;
	endtask
	task automatic ack(input logic a);
		@(negedge scl);
		sda_pull = a;
	endtask
	// next bit out, then hold the clock low for a while after the acknowledge
	task automatic rel(input logic v);
		@(negedge scl);
		sda_pull = v;
		if (stretch) begin
			scl_pull = 1'h1;
			#2000;
			scl_pull = 1'h0;
		end
	endtask
	task automatic session();
		rx();
		ack(!nak);
		if (nak) wait (1'h0);
		if (!b[0]) begin
			forever begin
				rel(1'h0);
				rx();
				ack(1'h1);
			end
		end
		forever begin
			rel(!rd_byte[7]);
			for (int i = 6; i >= 0; i--) begin
				@(negedge scl);
				sda_pull = !rd_byte[i];
			end
			ack(1'h0);
			@(posedge scl);
			if (sda) wait (1'h0);
		end
	endtask
	initial begin
		sda_pull = 1'h0;
		scl_pull = 1'h0;
		got = 8'h00;
		got_tgl = 1'h0;
		b = 8'h00;
		forever begin
			@(negedge sda iff scl === 1'h1);
			fork
				session();
				@(posedge sda iff scl === 1'h1);
			join_any
			disable fork;
			sda_pull = 1'h0;
			scl_pull = 1'h0;
		end
	end
endmodule

/* verif/bbi2c_top_tb.sv */
// self-checking bench: registers, override, write, read, nak, disable
`include "bbi2c_regs.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fail_count++; \
	$display("Error %s expected %h seen %h", n, e, s); end end
module bbi2c_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_sys, rst, reg_wr, reg_rd, nak, stretch, ck, rd_q, got_tgl, irq;
	logic [1:0]  lvl;
	logic        sda_oe, scl_oe, sda_pull, scl_pull;
	logic [31:0] reg_addr, reg_wdata, reg_rdata, v, w;
	logic [7:0]  got, rd_byte;
	logic [63:0] e;
	wire         sda = !(sda_oe || sda_pull);
	wire         scl = !(scl_oe || scl_pull);
	int          checks, fail_count;
	logic [63:0] exp_q[$];
	logic [7:0]  byte_q[$];
	bbi2c_top dut (.clk_sys(clk_sys), .rst(rst), .clk_en(1'h1), .boot_clk_sel(2'h3),
		.boot_fast(1'h1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sda_i(sda), .sda_o(lvl[1]),
		.sda_oe(sda_oe), .scl_i(scl), .scl_o(lvl[0]), .scl_oe(scl_oe), .irq_req(irq));
	bbi2c_slave_model u_slave (.scl(scl), .sda(sda), .sda_pull(sda_pull), .scl_pull(scl_pull),
		.nak(nak), .stretch(stretch), .rd_byte(rd_byte), .got(got), .got_tgl(got_tgl));
	initial begin
		clk_sys = 1'h0;
		forever #20 clk_sys = ~clk_sys;
	end
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk_sys) rd_q <= reg_rd && ck;
	always @(negedge clk_sys) begin
		if (rd_q) begin
			e = exp_q.pop_front();
			`CHK("reg_rdata", e[31:0], reg_rdata & e[63:32])
		end
	end
	// the model's power-up toggle is not a bus byte
	always @(got_tgl) if (!rst) `CHK("bus byte", byte_q.pop_front(), got)
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		reg_wr = 1'h1;
		reg_addr = a;
		reg_wdata = d;
		@(negedge clk_sys);
		reg_wr = 1'h0;
	endtask
	task automatic rd(input logic [31:0] a);
		@(negedge clk_sys);
		reg_rd = 1'h1;
		reg_addr = a;
		@(negedge clk_sys);
		reg_rd = 1'h0;
		v = reg_rdata;
	endtask
	task automatic chk(input logic [31:0] a, input logic [31:0] x, input logic [31:0] m);
		exp_q.push_back({m, x & m});
		ck = 1'h1;
		rd(a);
		ck = 1'h0;
	endtask
	// bounded poll of one status flag
	task automatic wait_st(input int b);
		int n = 0;
		do begin
			rd(`BBI2C_STAT_ADDR);
			n++;
		end while (v[b] !== 1'h1 && n < 3000);
		if (n >= 3000) begin
			fail_count++;
			report_and_stop();
		end
		// let a stop run out before the next setup write, else it is refused
		repeat (200) @(negedge clk_sys);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] ovr[4] = '{32'h440, 32'h4c0, 32'h480, 32'h400};
		{rst, reg_wr, reg_rd, nak, stretch, ck} = 6'h20;
		reg_addr = 32'h0;
		reg_wdata = 32'h0;
		void'($urandom(88));
		rd_byte = 8'($urandom());
		w = $urandom();
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys) rst = 1'h0;
		chk(`BBI2C_CTRL_ADDR, 32'h0, 32'hffffffff);
		chk(`BBI2C_STAT_ADDR, 32'h0, 32'hffffffff);
		chk(32'h00103410, 32'h0, 32'hffffffff);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			wr(`BBI2C_CTRL_ADDR, ovr[i]);
			repeat (3) @(negedge clk_sys);
			chk(`BBI2C_STAT_ADDR, {30'h0, ovr[i][7:6]}, 32'hffffffff);
			chk(`BBI2C_CTRL_ADDR, ovr[i], 32'hffffffff);
		end
		wr(`BBI2C_CTRL_ADDR, 32'h0);
		$display("test override done");
		wr(`BBI2C_CTRL_ADDR, 32'hf3c00001);
		stretch = 1'h1;
		byte_q = '{8'ha0, w[31:24], w[23:16], w[15:8], w[7:0], rd_byte};
		wr(`BBI2C_SETUP_ADDR, 32'ha0000500);
		wr(`BBI2C_WIN_ADDR, w);
		wait_st(30);
		chk(`BBI2C_STAT_ADDR, 32'h40000150, 32'hf000fff8);
		wr(`BBI2C_CTRL_ADDR, 32'hf3000001);
		wr(`BBI2C_WIN_ADDR, {rd_byte, ~w[23:0]});
		wait_st(31);
		chk(`BBI2C_STAT_ADDR, 32'h80000000, 32'hf000ff08);
		`CHK("irq_req", 1'h1, irq)
		`CHK("pin level", 2'h0, lvl)
		$display("test write done");
		wr(`BBI2C_CTRL_ADDR, 32'hf3c00001);
		stretch = 1'h0;
		byte_q.push_back(8'ha1);
		wr(`BBI2C_SETUP_ADDR, 32'ha1000200);
		wait_st(31);
		chk(`BBI2C_WIN_ADDR, {rd_byte, rd_byte, 16'h0}, 32'hffffffff);
		chk(`BBI2C_SETUP_ADDR, 32'ha1000200, 32'hff00ff00);
		$display("test read done");
		wr(`BBI2C_CTRL_ADDR, 32'hf3c00001);
		nak = 1'h1;
		byte_q.push_back(8'ha0);
		wr(`BBI2C_SETUP_ADDR, 32'ha0000100);
		wr(`BBI2C_WIN_ADDR, 32'h5a000000);
		wait_st(29);
		repeat (300) @(negedge clk_sys);
		chk(`BBI2C_STAT_ADDR, 32'h20000100, 32'hf000ff70);
		nak = 1'h0;
		$display("test nak done");
		wr(`BBI2C_CTRL_ADDR, 32'h0);
		chk(`BBI2C_STAT_ADDR, 32'h0, 32'hf000ff00);
		`CHK("irq_req", 1'h0, irq)
		$display("test disable done");
		repeat (4) @(negedge clk_sys);
		`CHK("bytes left", 0, byte_q.size())
		report_and_stop();
	end
endmodule
